// File: rtl/standby_pkg.sv
// standby_pkg: register map, field positions, reset values, settling
// counts, states and carrier structs of the standby power-down control.
// assumes a 32-bit classic wishbone slave with byte addresses.
package standby_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  SCTRL_OFS       = 8'h00;
    localparam logic [7:0]  IRQ_EN_OFS      = 8'h04;
    localparam logic [7:0]  STATUS_OFS      = 8'h08;
    localparam logic [7:0]  SLEEP_CMD_OFS   = 8'h0C;

    // ------------------------------------------------------------
    // system control register fields
    // ------------------------------------------------------------
    localparam int          SB_SEL_BIT      = 7;
    localparam int          STS_LSB         = 4;
    localparam int          STS_W           = 3;
    localparam int          XRST_BIT        = 3;
    localparam int          NMI_EG_BIT      = 2;
    localparam int          HIE_BIT         = 1;
    localparam int          RAM_EN_BIT      = 0;
    localparam logic [7:0]  SCTRL_RESET     = 8'h09;
    localparam logic [7:0]  SCTRL_WMASK     = 8'hF7;
    localparam logic [7:0]  IRQ_EN_RESET    = 8'h00;
    localparam int          SLEEP_GO_BIT    = 0;
    localparam int          STAT_STATE_LSB  = 0;
    localparam int          STAT_BUSY_BIT   = 3;

    // ------------------------------------------------------------
    // wake sources and settling counts in states
    // ------------------------------------------------------------
    localparam logic [7:0]  WAKE_IRQ_MASK   = 8'h47;
    localparam int          KEY_IRQ_IDX     = 6;
    localparam int          SETTLE_CNT_W    = 18;
    localparam int          SETTLE_ST_000   = 8192;
    localparam int          SETTLE_ST_001   = 16384;
    localparam int          SETTLE_ST_010   = 32768;
    localparam int          SETTLE_ST_011   = 65536;
    localparam int          SETTLE_ST_100   = 131072;
    localparam int          SETTLE_ST_101   = 1024;

    // ------------------------------------------------------------
    // states and carriers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN        = 3'b000,
        ST_SLEEP      = 3'b001,
        ST_SW_HW_HALT_N    = 3'b010,
        ST_SETTLE     = 3'b011,
        ST_HW_HW_HALT_N    = 3'b100,
        ST_RESET_HOLD = 3'b101
    } pwr_state_e;

    typedef struct packed {
        logic clk_run;
        logic osc_run;
        logic cpu_halt;
        logic periph_reset;
        logic io_hold;
        logic io_float;
    } pwr_out_s;

    typedef struct packed {
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
        logic [3:0]        sel;
        logic              we;
    } wb_req_s;

endpackage

// File: rtl/wake_detect.sv
// wake_detect: edge detection on the interrupt pins, giving one-cycle
// wake pulses for sleep and for software standby.
// assumes pins already synchronous to clk_i; interrupt pins active low.
`timescale 1ns/100ps
module wake_detect (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       nmi_n_i,
    input  wire logic       nmi_rising_i,
    input  wire logic [7:0] irq_n_i,
    input  wire logic [7:0] irq_en_i,
    output logic            hw_halt_n_wake_o,
    output logic            any_wake_o
);
    logic       nmi_prev_reg;
    logic [7:0] irq_prev_reg;
    logic       hw_halt_n_wake_reg;
    logic       any_wake_reg;
    wire        nmi_evt;
    wire  [7:0] irq_fall;

    assign nmi_evt  = nmi_rising_i ? (!nmi_prev_reg && nmi_n_i)
                                   : (nmi_prev_reg && !nmi_n_i);
    assign irq_fall = irq_prev_reg & ~irq_n_i & irq_en_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_prev_reg  <= 1'b1;
            irq_prev_reg  <= 8'hFF;
            hw_halt_n_wake_reg <= 1'b0;
            any_wake_reg  <= 1'b0;
        end else begin
            nmi_prev_reg  <= nmi_n_i;
            irq_prev_reg  <= irq_n_i;
            hw_halt_n_wake_reg <= nmi_evt
                             || |(irq_fall & standby_pkg::WAKE_IRQ_MASK);
            any_wake_reg  <= nmi_evt || |irq_fall;
        end
    end

    assign hw_halt_n_wake_o = hw_halt_n_wake_reg;
    assign any_wake_o  = any_wake_reg;
endmodule

// File: rtl/settle_timer.sv
// settle_timer: oscillator settling countdown selected by a 3-bit code.
// assumes start is a one-cycle pulse; abort stops a running count.
`timescale 1ns/100ps
module settle_timer #(
    parameter int S000 = standby_pkg::SETTLE_ST_000,
    parameter int S001 = standby_pkg::SETTLE_ST_001,
    parameter int S010 = standby_pkg::SETTLE_ST_010,
    parameter int S011 = standby_pkg::SETTLE_ST_011,
    parameter int S100 = standby_pkg::SETTLE_ST_100,
    parameter int S101 = standby_pkg::SETTLE_ST_101
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic       abort_i,
    input  wire logic [2:0] code_i,
    output logic            busy_o,
    output logic            done_o
);
    localparam int CW = standby_pkg::SETTLE_CNT_W;

    logic [CW-1:0] cnt_reg;
    logic          busy_reg;
    logic          done_reg;
    wire  [CW-1:0] load_val;

    // code to settling count, minus one
    function automatic logic [CW-1:0] count_for(input logic [2:0] c);
        unique case (c)
            3'b000:  count_for = CW'(S000 - 1);
            3'b001:  count_for = CW'(S001 - 1);
            3'b010:  count_for = CW'(S010 - 1);
            3'b011:  count_for = CW'(S011 - 1);
            3'b100:  count_for = CW'(S100 - 1);
            3'b101:  count_for = CW'(S101 - 1);
            default: count_for = CW'(S100 - 1);
        endcase
    endfunction

    assign load_val = count_for(code_i);

    always_ff @(posedge clk_i) begin
        if (rst_i || abort_i) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (start_i) begin
            cnt_reg  <= load_val;
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
        end else if (busy_reg) begin
            cnt_reg  <= cnt_reg - CW'(1);
            busy_reg <= (cnt_reg != '0);
            done_reg <= (cnt_reg == '0);
        end else begin
            done_reg <= 1'b0;
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;
endmodule

// File: rtl/standby_ctrl.sv
// standby_ctrl: power-down sequencer for software and hardware standby,
// with its control registers on a classic wishbone slave.
// assumes pins synchronous to clk_i; reset, standby and interrupt pins
// active low; clk_i keeps running (the gated clock is clk_run).
//
// Operation
// - standby select set before sleep gives software standby, else sleep
// - software standby stops system clock, halts processor and peripherals
// - entering standby resets peripherals; processor state and ram kept
// - io pins hold their state during software standby
// - standby exits only by reset, standby pin, nmi, irq 0-2 or 6
// - wake interrupt starts oscillator, waits settling, then resumes
// - reset low in standby starts oscillator; held low until stable
// - standby pin low in software standby goes to hardware standby
// - settle code picks 8192 to 131072 states, 101 gives 1024
// - nmi edge bit: 0 falling, 1 rising, also for wake
// - standby pin low enters hardware standby from any state
// - hardware standby halts all, resets peripherals, floats io
// - standby pin high starts oscillator; reset rise resumes program
// - standby select at bit 7, settle code at bits 6 to 4
// - wake by interrupt leaves standby select at 1
// - during settling oscillator runs, processor and peripherals held
`timescale 1ns/100ps
module standby_ctrl #(
    parameter int S000 = standby_pkg::SETTLE_ST_000,
    parameter int S001 = standby_pkg::SETTLE_ST_001,
    parameter int S010 = standby_pkg::SETTLE_ST_010,
    parameter int S011 = standby_pkg::SETTLE_ST_011,
    parameter int S100 = standby_pkg::SETTLE_ST_100,
    parameter int S101 = standby_pkg::SETTLE_ST_101
) (
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    input  wire logic                            wb_cyc_i,
    input  wire logic                            wb_stb_i,
    input  wire logic                            wb_we_i,
    input  wire logic [standby_pkg::ADDR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]                      wb_sel_i,
    input  wire logic [standby_pkg::DATA_W-1:0]  wb_dat_i,
    output logic      [standby_pkg::DATA_W-1:0]  wb_dat_o,
    output logic                                 wb_ack_o,
    input  wire logic                            chip_clear_n_i,
    input  wire logic                            hw_halt_n_i,
    input  wire logic                            nmi_n_i,
    input  wire logic [7:0]                      irq_n_i,
    input  wire logic                            key_wake_in0_n_i,
    output standby_pkg::pwr_out_s                pwr_o,
    output logic                                 ram_enable_o,
    output logic                                 int_exc_o,
    output logic                                 reset_exc_o
);

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    standby_pkg::pwr_state_e state_reg;
    standby_pkg::pwr_state_e state_next;
    standby_pkg::pwr_out_s   pwr_reg;
    standby_pkg::wb_req_s    req;

    logic [7:0]                     system_control_reg;
    logic [7:0]                     irq_en_reg;
    logic [standby_pkg::DATA_W-1:0] dat_reg;
    logic                           ack_reg;
    logic                           int_exc_reg;
    logic                           reset_exc_reg;

    wire        standby_select_bit;
    wire [2:0]  settle_time_sel;
    wire        nmi_edge_polarity_bit;
    wire        ram_enable_bit;
    wire [7:0]  irq_pins_n;
    wire        hw_halt_n_wake;
    wire        any_wake;
    wire        settle_busy;
    wire        settle_done;
    wire        settle_start;
    wire        settle_abort;
    wire        bus_take;
    wire        bus_wr;
    wire        wr_sctrl;
    wire        wr_irq_en;
    wire        sleep_req;
    wire        regs_init;
    wire [7:0]  sctrl_wr_val;
    wire [7:0]  status_val;
    wire [standby_pkg::DATA_W-1:0] rd_mux;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    // field positions
    assign standby_select_bit    = system_control_reg[standby_pkg::SB_SEL_BIT];
    assign settle_time_sel       = system_control_reg[standby_pkg::STS_LSB
                                   +: standby_pkg::STS_W];
    assign nmi_edge_polarity_bit = system_control_reg[standby_pkg::NMI_EG_BIT];
    assign ram_enable_bit        = system_control_reg[standby_pkg::RAM_EN_BIT];

    // key input 0 shares the irq 6 wake line
    assign irq_pins_n = irq_n_i & ~(8'h01 << standby_pkg::KEY_IRQ_IDX)
                        | ({8{key_wake_in0_n_i & irq_n_i[6]}}
                           & (8'h01 << standby_pkg::KEY_IRQ_IDX));

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    assign req.adr   = wb_adr_i;
    assign req.dat   = wb_dat_i;
    assign req.sel   = wb_sel_i;
    assign req.we    = wb_we_i;
    assign bus_take  = wb_cyc_i && wb_stb_i && !ack_reg;
    assign bus_wr    = wb_cyc_i && wb_stb_i && ack_reg
                       && req.we && req.sel[0];
    assign wr_sctrl  = bus_wr && (req.adr == standby_pkg::SCTRL_OFS);
    assign wr_irq_en = bus_wr && (req.adr == standby_pkg::IRQ_EN_OFS);
    // sleep instruction as a command write
    assign sleep_req = bus_wr && (req.adr == standby_pkg::SLEEP_CMD_OFS)
                       && req.dat[standby_pkg::SLEEP_GO_BIT];

    assign sctrl_wr_val = (req.dat[7:0] & standby_pkg::SCTRL_WMASK)
                          | (standby_pkg::SCTRL_RESET
                             & ~standby_pkg::SCTRL_WMASK);

    assign status_val = {4'h0, settle_busy, state_reg};

    assign rd_mux =
        (req.adr == standby_pkg::SCTRL_OFS)  ? {24'h00_0000,
                                                system_control_reg} :
        (req.adr == standby_pkg::IRQ_EN_OFS) ? {24'h00_0000, irq_en_reg} :
        (req.adr == standby_pkg::STATUS_OFS) ? {24'h00_0000, status_val} :
                                               32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= bus_take;
            dat_reg <= bus_take ? rd_mux : dat_reg;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // hardware standby and reset reinitialise registers
    assign regs_init = (state_next == standby_pkg::ST_HW_HW_HALT_N)
                       || (state_next == standby_pkg::ST_RESET_HOLD);

    always_ff @(posedge clk_i) begin
        if (rst_i || regs_init) begin
            system_control_reg <= standby_pkg::SCTRL_RESET;
            irq_en_reg         <= standby_pkg::IRQ_EN_RESET;
        // a software write, hardware standby or reset clears select
        end else begin
            if (wr_sctrl)
                system_control_reg <= sctrl_wr_val;
            if (wr_irq_en)
                irq_en_reg <= req.dat[7:0];
        end
    end

    // ------------------------------------------------------------
    // wake detection and settling timer
    // ------------------------------------------------------------
    wake_detect u_wake (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .nmi_n_i      (nmi_n_i),
        .nmi_rising_i (nmi_edge_polarity_bit),
        .irq_n_i      (irq_pins_n),
        .irq_en_i     (irq_en_reg),
        .hw_halt_n_wake_o  (hw_halt_n_wake),
        .any_wake_o   (any_wake)
    );

    assign settle_start = (state_reg == standby_pkg::ST_SW_HW_HALT_N)
                          && (state_next == standby_pkg::ST_SETTLE);
    assign settle_abort = (state_reg == standby_pkg::ST_SETTLE)
                          && (state_next != standby_pkg::ST_SETTLE)
                          && (state_next != standby_pkg::ST_RUN);

    settle_timer #(
        .S000 (S000),
        .S001 (S001),
        .S010 (S010),
        .S011 (S011),
        .S100 (S100),
        .S101 (S101)
    ) u_settle (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (settle_start),
        .abort_i (settle_abort),
        .code_i  (settle_time_sel),
        .busy_o  (settle_busy),
        .done_o  (settle_done)
    );

    // ------------------------------------------------------------
    // power state sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        // standby pin wins from any state
        if (!hw_halt_n_i) begin
            state_next = standby_pkg::ST_HW_HW_HALT_N;
        end else if (!chip_clear_n_i
                     && state_reg != standby_pkg::ST_HW_HW_HALT_N) begin
            state_next = standby_pkg::ST_RESET_HOLD;
        end else begin
            unique case (state_reg)
                standby_pkg::ST_RUN: begin
                    if (sleep_req)
                        state_next = standby_select_bit
                                     ? standby_pkg::ST_SW_HW_HALT_N
                                     : standby_pkg::ST_SLEEP;
                end
                standby_pkg::ST_SLEEP: begin
                    if (any_wake)
                        state_next = standby_pkg::ST_RUN;
                end
                standby_pkg::ST_SW_HW_HALT_N: begin
                    if (hw_halt_n_wake)
                        state_next = standby_pkg::ST_SETTLE;
                end
                standby_pkg::ST_SETTLE: begin
                    if (settle_done)
                        state_next = standby_pkg::ST_RUN;
                end
                // standby pin rise then reset rise
                standby_pkg::ST_HW_HW_HALT_N: begin
                    state_next = standby_pkg::ST_RESET_HOLD;
                end
                standby_pkg::ST_RESET_HOLD: begin
                    state_next = standby_pkg::ST_RUN;
                end
                default: begin
                    state_next = standby_pkg::ST_RESET_HOLD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // power controls per state
    // ------------------------------------------------------------
    function automatic standby_pkg::pwr_out_s outs_for(
        input standby_pkg::pwr_state_e s);
        standby_pkg::pwr_out_s o;
        o = '0;
        unique case (s)
            standby_pkg::ST_RUN: begin
                o.clk_run = 1'b1;
                o.osc_run = 1'b1;
            end
            standby_pkg::ST_SLEEP: begin
                o.clk_run  = 1'b1;
                o.osc_run  = 1'b1;
                o.cpu_halt = 1'b1;
            end
            // peripherals reset, cpu and ram kept
            standby_pkg::ST_SW_HW_HALT_N: begin
                o.cpu_halt     = 1'b1;
                o.periph_reset = 1'b1;
                o.io_hold      = 1'b1;
            end
            standby_pkg::ST_SETTLE: begin
                o.osc_run      = 1'b1;
                o.cpu_halt     = 1'b1;
                o.periph_reset = 1'b1;
                o.io_hold      = 1'b1;
            end
            standby_pkg::ST_HW_HW_HALT_N: begin
                o.cpu_halt     = 1'b1;
                o.periph_reset = 1'b1;
                o.io_float     = 1'b1;
            end
            standby_pkg::ST_RESET_HOLD: begin
                o.clk_run      = 1'b1;
                o.osc_run      = 1'b1;
                o.cpu_halt     = 1'b1;
                o.periph_reset = 1'b1;
            end
            default: begin
                o.cpu_halt     = 1'b1;
                o.periph_reset = 1'b1;
            end
        endcase
        return o;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg     <= standby_pkg::ST_RUN;
            pwr_reg       <= outs_for(standby_pkg::ST_RUN);
            int_exc_reg   <= 1'b0;
            reset_exc_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            pwr_reg       <= outs_for(state_next);
            int_exc_reg   <= (state_next == standby_pkg::ST_RUN)
                             && (state_reg == standby_pkg::ST_SETTLE
                                 || state_reg == standby_pkg::ST_SLEEP);
            reset_exc_reg <= (state_next == standby_pkg::ST_RUN)
                             && (state_reg == standby_pkg::ST_RESET_HOLD);
        end
    end

    assign wb_dat_o     = dat_reg;
    assign wb_ack_o     = ack_reg;
    assign pwr_o        = pwr_reg;
    assign ram_enable_o = ram_enable_bit;
    assign int_exc_o    = int_exc_reg;
    assign reset_exc_o  = reset_exc_reg;

endmodule

// File: tb/standby_ctrl_asserts.sv
// checker for the power sequencing outputs of standby_ctrl
// assumes it is bound into standby_ctrl, sync reset rst_i
`timescale 1ns/100ps
module standby_ctrl_asserts (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  chip_clear_n_i,
    input wire logic                  hw_halt_n_i,
    input wire standby_pkg::pwr_out_s pwr_o,
    input wire logic                  int_exc_o,
    input wire logic                  reset_exc_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_hw_in;
        $fell(hw_halt_n_i) |-> ##[1:2] pwr_o.io_float;
    endproperty
    a_hw_in: assert property (p_hw_in)
        else $error("standby pin low, io not floated");
    property p_hw_st;
        pwr_o.io_float |-> !pwr_o.clk_run && !pwr_o.osc_run
            && pwr_o.cpu_halt && pwr_o.periph_reset;
    endproperty
    a_hw_st: assert property (p_hw_st)
        else $error("hardware standby outputs wrong");
    property p_sw_st;
        pwr_o.io_hold && !pwr_o.osc_run |-> !pwr_o.clk_run
            && pwr_o.cpu_halt && pwr_o.periph_reset;
    endproperty
    a_sw_st: assert property (p_sw_st)
        else $error("software standby outputs wrong");
    property p_hold; pwr_o.io_hold |-> !pwr_o.io_float; endproperty
    a_hold: assert property (p_hold)
        else $error("held io also floated");
    property p_settle;
        pwr_o.osc_run && !pwr_o.clk_run |-> pwr_o.cpu_halt
            && pwr_o.periph_reset;
    endproperty
    a_settle: assert property (p_settle)
        else $error("settling without halt");
    property p_resume;
        $rose(pwr_o.clk_run) && $past(pwr_o.osc_run) && !pwr_o.cpu_halt
            |-> int_exc_o;
    endproperty
    a_resume: assert property (p_resume)
        else $error("clock released without interrupt start");
    property p_int;
        int_exc_o |-> pwr_o.clk_run && !pwr_o.cpu_halt ##1 !int_exc_o;
    endproperty
    a_int: assert property (p_int)
        else $error("interrupt start pulse wrong");
    property p_pin_rst;
        $fell(chip_clear_n_i) && hw_halt_n_i |-> ##[1:2]
            (pwr_o.osc_run && pwr_o.cpu_halt);
    endproperty
    a_pin_rst: assert property (p_pin_rst)
        else $error("reset pin low, oscillator not run");
    property p_rst_exc;
        reset_exc_o |-> pwr_o.clk_run && !pwr_o.cpu_halt ##1 !reset_exc_o;
    endproperty
    a_rst_exc: assert property (p_rst_exc)
        else $error("reset start pulse wrong");
    c_wake: cover property (int_exc_o);
    c_float: cover property (pwr_o.io_float);
    c_rst: cover property (reset_exc_o);
endmodule
bind standby_ctrl standby_ctrl_asserts u_asserts (.*);

// File: tb/pin_driver_model.sv
// pin_driver_model: drives reset, standby and interrupt pins
// assumes clk_i is the design clock; pins active low, idle high
`timescale 1ns/100ps
module pin_driver_model (
    input  wire logic  clk_i,
    output logic       chip_clear_n_o,
    output logic       hw_halt_n_o,
    output logic       nmi_n_o,
    output logic [7:0] irq_n_o
);
    initial begin
        chip_clear_n_o = 1'b1;
        hw_halt_n_o    = 1'b1;
        nmi_n_o        = 1'b1;
        irq_n_o        = 8'hFF;
    end
    task automatic hw_enter();
        @(posedge clk_i) chip_clear_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        hw_halt_n_o <= 1'b0;
    endtask
    task automatic hw_exit(input int settle);
        @(posedge clk_i) hw_halt_n_o <= 1'b1;
        repeat (settle) @(posedge clk_i);
        chip_clear_n_o <= 1'b1;
    endtask
    task automatic pulse_irq(input int idx);
        @(posedge clk_i) irq_n_o[idx] <= 1'b0;
        repeat (3) @(posedge clk_i);
        irq_n_o[idx] <= 1'b1;
    endtask
    task automatic set_nmi(input logic lvl);
        @(posedge clk_i) nmi_n_o <= lvl;
    endtask
endmodule

// File: tb/test_standby_ctrl.sv
// test_standby_ctrl: register and pin sequences for standby_ctrl
// assumes the checker binds itself; settling counts are shortened
`timescale 1ns/100ps
module test_standby_ctrl;
    localparam int SETL [6] = '{16, 32, 64, 128, 256, 8};
    logic                  clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
    logic                  int_exc, reset_exc, ram_en, clear_n, halt_n;
    logic                  nmi_n, key_n;
    logic [7:0]            wb_adr, irq_n;
    logic [3:0]            wb_sel;
    logic [31:0]           wb_wdat, wb_rdat, rd;
    standby_pkg::pwr_out_s pwr;
    int                    mismatches = 0;
    int                    checked = 0;
    int                    n;
    standby_ctrl #(.S000(SETL[0]), .S001(SETL[1]), .S010(SETL[2]),
        .S011(SETL[3]), .S100(SETL[4]), .S101(SETL[5])) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .chip_clear_n_i(clear_n), .hw_halt_n_i(halt_n), .nmi_n_i(nmi_n),
        .irq_n_i(irq_n), .key_wake_in0_n_i(key_n), .pwr_o(pwr),
        .ram_enable_o(ram_en), .int_exc_o(int_exc),
        .reset_exc_o(reset_exc));
    pin_driver_model pins (.clk_i(clk_i), .chip_clear_n_o(clear_n),
        .hw_halt_n_o(halt_n), .nmi_n_o(nmi_n), .irq_n_o(irq_n));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wb_io(input logic we, input logic [7:0] adr,
                         input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (k >= 50) mismatches++;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_io(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb_io(1'b0, a, 32'h0000_0000);
        check(rd, e);
    endtask
    // counts edges until a start pulse is sampled
    task automatic wait_pulse(input bit rkind);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((rkind ? reset_exc : int_exc) !== 1'b1 && n < 2000);
        if (n >= 2000) mismatches++;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
        wb_sel = 4'h1;
        key_n = 1'b1;
        rst_i = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(8'h00, 32'h0000_0009);
        rd_chk(8'h04, 32'h0000_0000);
        $display("reset values done");
        wr(8'h04, 32'h0000_0001);
        for (int c = 0; c < 6; c++) begin
            wr(8'h00, 32'h0000_0081 | (c << 4));
            wr(8'h0C, 32'h0000_0001);
            rd_chk(8'h08, 32'h0000_0002);
            check({26'h0, pwr}, 32'h0000_000E);
            fork
                pins.pulse_irq(0);
                begin @(posedge clk_i); wait_pulse(1'b0); end
            join
            check(n, SETL[c] + 4);
            check({26'h0, pwr}, 32'h0000_0030);
            rd_chk(8'h00, 32'h0000_0089 | (c << 4));
        end
        $display("settle codes done");
        wr(8'h04, 32'h0000_0008);
        wr(8'h00, 32'h0000_0085);
        wr(8'h0C, 32'h0000_0001);
        pins.pulse_irq(3);
        pins.set_nmi(1'b0);
        repeat (20) @(posedge clk_i);
        rd_chk(8'h08, 32'h0000_0002);
        fork
            pins.set_nmi(1'b1);
            begin @(posedge clk_i); wait_pulse(1'b0); end
        join
        check(n, SETL[0] + 4);
        wr(8'h04, 32'h0000_0040);
        wr(8'h0C, 32'h0000_0001);
        key_n <= 1'b0;
        wait_pulse(1'b0);
        check(n, SETL[0] + 4);
        $display("wake sources done");
        for (int k = 0; k < 2; k++) begin
            wr(8'h00, 32'h0000_0080);
            if (k == 0) wr(8'h0C, 32'h0000_0001);
            pins.hw_enter();
            repeat (3) @(posedge clk_i);
            check({26'h0, pwr}, 32'h0000_000D);
            check({31'h0, ram_en}, 32'h0000_0001);
            fork
                pins.hw_exit(SETL[4]);
                begin @(posedge clk_i); wait_pulse(1'b1); end
            join
            check({26'h0, pwr}, 32'h0000_0030);
            rd_chk(8'h00, 32'h0000_0009);
        end
        $display("hardware standby done");
        tally_and_finish();
    end
endmodule
